// ### src/scb_top.sv
// Purpose: chip clock control and brownout reset
// Assumes: one 250 MHz clock; crystal and synthesizer edges arrive as enable ticks
// Notes: analog trims only stored and driven out
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "scb_cfg.svh"
module scb_top
  import scb_pkg::*;
#(
  parameter int HOLD_CYCLES = `SCB_HOLD_XTAL_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic xtal_tick,
  input wire logic synth_tick,
  input wire logic synth_locked,
  input wire logic below_low,
  input wire logic above_upper,
  output logic chip_reset,
  output logic [1:0] low_trip_level_select,
  output logic synth_power_down,
  output logic [3:0] synth_m_code,
  output logic [1:0] synth_n_code,
  output logic [3:0] synth_filter_trim,
  output logic [1:0] synth_test_vset,
  output logic sys_on_synth,
  output logic sys_clk_tick
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] brown;
    logic [7:0] stat;
    logic [7:0] filt;
    logic [7:0] ratio;
    logic sel_req;
    scb_sel_type sel;
    logic [1:0] xs;
    logic [1:0] ss;
    logic src_tick;
    logic [7:0] rdata;
  } scb_top_type;
  scb_top_type s_r;
  scb_top_type s_nxt;
  logic unstable;
  logic bo_reset;
  logic div_tick;
  logic chip_reset_r;
  logic div_tick_r;
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction
  // ----------------------------------------------------------------
  // brownout and post-divider
  // ----------------------------------------------------------------
  scb_brownout #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_bo (
    .clk(clk),
    .nrst(nrst),
    .xtal_tick(xtal_tick),
    .below_low(below_low),
    .above_upper(above_upper),
    .chip_reset(bo_reset)
  );
  scb_post_div u_div (
    .clk(clk),
    .nrst(nrst && !bo_reset),
    .en(s_r.src_tick),
    .div_code(s_r.ratio[`SCB_DIV_HI:`SCB_DIV_LO]),
    .tick(div_tick)
  );
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    unstable = s_r.stat[`SCB_STAT_PWDN_BIT] || !synth_locked;
    s_nxt.stat[`SCB_STAT_UNSTABLE_BIT] = unstable;
    s_nxt.rdata = 8'h00;
    if (wr)
    begin
      if (hit(addr, `SCB_ADDR_BROWNOUT))
      begin
        s_nxt.brown = {wdata[`SCB_LOW_TRIP_HI:`SCB_LOW_TRIP_LO], 6'h00};
      end
      if (hit(addr, `SCB_ADDR_SYNTH_STAT))
      begin
        s_nxt.stat = (wdata & `SCB_STAT_RW_MASK) | {unstable, 7'h00};
      end
      if (hit(addr, `SCB_ADDR_SYNTH_FILT))
      begin
        s_nxt.filt = wdata & `SCB_FILT_RW_MASK;
      end
      if (hit(addr, `SCB_ADDR_SYNTH_RATIO))
      begin
        s_nxt.ratio = wdata;
      end
      if (hit(addr, `SCB_ADDR_CLK_SEL))
      begin
        s_nxt.sel_req = wdata[0];
      end
    end
    if (rd)
    begin
      if (hit(addr, `SCB_ADDR_BROWNOUT))
      begin
        s_nxt.rdata = s_r.brown;
      end
      else if (hit(addr, `SCB_ADDR_SYNTH_STAT))
      begin
        s_nxt.rdata = s_r.stat;
      end
      else if (hit(addr, `SCB_ADDR_SYNTH_FILT))
      begin
        s_nxt.rdata = s_r.filt;
      end
      else if (hit(addr, `SCB_ADDR_SYNTH_RATIO))
      begin
        s_nxt.rdata = s_r.ratio;
      end
      else if (hit(addr, `SCB_ADDR_CLK_SEL))
      begin
        s_nxt.rdata = {6'h00, (s_r.sel == SCB_SEL_SYNTH), s_r.sel_req};
      end
      else
      begin
        s_nxt.rdata = 8'h00;
      end
    end
    // handover to the synthesizer waits for an edge of the old and then the new source; the return to the crystal is immediate
    s_nxt.xs = 2'b00;
    s_nxt.ss = 2'b00;
    case (s_r.sel)
      SCB_SEL_XTAL:
      begin
        s_nxt.src_tick = xtal_tick;
        if (s_r.sel_req && !unstable)
        begin
          s_nxt.sel = SCB_SEL_WAIT;
        end
      end
      SCB_SEL_WAIT:
      begin
        s_nxt.src_tick = 1'b0;
        s_nxt.xs = s_r.xs | {1'b0, xtal_tick};
        s_nxt.ss = s_r.ss | {1'b0, s_r.xs[0] & synth_tick};
        if (!s_r.sel_req || unstable)
        begin
          s_nxt.sel = SCB_SEL_XTAL;
        end
        else if (s_r.ss[0])
        begin
          s_nxt.sel = SCB_SEL_SYNTH;
        end
      end
      SCB_SEL_SYNTH:
      begin
        s_nxt.src_tick = synth_tick;
        if (!s_r.sel_req || unstable)
        begin
          s_nxt.sel = SCB_SEL_XTAL;
        end
      end
      default:
      begin
        s_nxt.sel = SCB_SEL_XTAL;
        s_nxt.src_tick = 1'b0;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst || bo_reset)
    begin
      s_r <= '{brown: `SCB_RST_BROWNOUT, stat: `SCB_RST_SYNTH_STAT, filt: `SCB_RST_SYNTH_FILT,
               ratio: `SCB_RST_SYNTH_RATIO, sel_req: 1'b0, sel: SCB_SEL_XTAL, xs: 2'b00,
               ss: 2'b00, src_tick: 1'b0, rdata: 8'h00};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      chip_reset_r <= 1'b1;
      div_tick_r <= 1'b0;
    end
    else
    begin
      chip_reset_r <= bo_reset;
      div_tick_r <= div_tick;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = s_r.rdata;
  assign chip_reset = chip_reset_r;
  assign low_trip_level_select = s_r.brown[`SCB_LOW_TRIP_HI:`SCB_LOW_TRIP_LO];
  assign synth_power_down = s_r.stat[`SCB_STAT_PWDN_BIT];
  assign synth_m_code = s_r.ratio[`SCB_M_HI:`SCB_M_LO];
  assign synth_n_code = s_r.ratio[`SCB_N_HI:`SCB_N_LO];
  assign synth_filter_trim = s_r.filt[3:0];
  assign synth_test_vset = s_r.stat[6:5];
  // only the synthesizer state has the upper code bit set
  assign sys_on_synth = s_r.sel[1];
  assign sys_clk_tick = div_tick_r;
endmodule

// ### src/scb_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte-wide register port, 16-bit address
// Notes: none
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH
`define SCB_ADDR_BROWNOUT 16'hFF0A
`define SCB_ADDR_SYNTH_STAT 16'hFF10
`define SCB_ADDR_SYNTH_FILT 16'hFF11
`define SCB_ADDR_SYNTH_RATIO 16'hFF12
`define SCB_ADDR_CLK_SEL 16'hFF13
`define SCB_RST_BROWNOUT 8'h00
`define SCB_RST_SYNTH_STAT 8'hC1
`define SCB_RST_SYNTH_FILT 8'h02
`define SCB_RST_SYNTH_RATIO 8'h10
`define SCB_STAT_UNSTABLE_BIT 7
`define SCB_STAT_PWDN_BIT 0
`define SCB_STAT_RW_MASK 8'h67
`define SCB_FILT_RW_MASK 8'h0F
`define SCB_LOW_TRIP_HI 7
`define SCB_LOW_TRIP_LO 6
`define SCB_M_HI 7
`define SCB_M_LO 4
`define SCB_N_HI 3
`define SCB_N_LO 2
`define SCB_DIV_HI 1
`define SCB_DIV_LO 0
`define SCB_HOLD_XTAL_CYCLES 65536
`define SCB_SWITCH_SYNC_STAGES 2
`endif

// ### src/scb_pkg.sv
// Purpose: shared types of the clock and brownout block
// Assumes: scb_cfg.svh holds the numbers
// Notes: none
package scb_pkg;
  typedef enum logic [1:0]
  {
    SCB_SEL_XTAL = 2'b00,
    SCB_SEL_WAIT = 2'b01,
    SCB_SEL_SYNTH = 2'b11
  } scb_sel_type;
  typedef enum logic [1:0]
  {
    SCB_BR_RESET = 2'b00,
    SCB_BR_HOLD = 2'b01,
    SCB_BR_RUN = 2'b11
  } scb_br_type;
endpackage

// ### src/scb_post_div.sv
// Purpose: glitch-free power-of-two post-divider enable
// Assumes: runs on the system clock
// Notes: new code taken only at a whole divided period boundary
`timescale 1ns/1ps
`include "scb_cfg.svh"
module scb_post_div
  import scb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [1:0] div_code,
  output logic tick
);
  typedef struct packed
  {
    logic [6:0] cnt;
    logic [1:0] code;
    logic tick;
  } scb_pd_type;
  scb_pd_type s_r;
  scb_pd_type s_nxt;
  logic [6:0] last;
  always_comb
  begin
    last = 7'((8'h01 << s_r.code) - 8'h01);
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    // counts source ticks, not system clock cycles
    if (en)
    begin
      if (s_r.cnt >= last)
      begin
        // boundary: only here the ratio changes, so no short period
        s_nxt.cnt = 7'h00;
        s_nxt.tick = 1'b1;
        s_nxt.code = div_code;
      end
      else
      begin
        s_nxt.cnt = 7'(s_r.cnt + 7'h01);
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign tick = s_r.tick;
endmodule

// ### src/scb_brownout.sv
// Purpose: brownout reset with post-recovery hold count
// Assumes: comparator levels arrive as synchronous inputs
// Notes: hold counts crystal ticks
`timescale 1ns/1ps
`include "scb_cfg.svh"
module scb_brownout
  import scb_pkg::*;
#(
  parameter int HOLD_CYCLES = `SCB_HOLD_XTAL_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic xtal_tick,
  input wire logic below_low,
  input wire logic above_upper,
  output logic chip_reset
);
  typedef struct packed
  {
    scb_br_type st;
    logic [16:0] cnt;
    logic rst;
  } scb_bo_type;
  scb_bo_type s_r;
  scb_bo_type s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      SCB_BR_RESET:
      begin
        s_nxt.rst = 1'b1;
        s_nxt.cnt = '0;
        if (above_upper && !below_low)
        begin
          s_nxt.st = SCB_BR_HOLD;
        end
      end
      SCB_BR_HOLD:
      begin
        if (below_low || !above_upper)
        begin
          s_nxt.st = SCB_BR_RESET;
        end
        else if (xtal_tick)
        begin
          if (s_r.cnt >= 17'(HOLD_CYCLES - 1))
          begin
            s_nxt.st = SCB_BR_RUN;
            s_nxt.rst = 1'b0;
          end
          else
          begin
            s_nxt.cnt = 17'(s_r.cnt + 17'h00001);
          end
        end
      end
      SCB_BR_RUN:
      begin
        if (below_low)
        begin
          s_nxt.st = SCB_BR_RESET;
          s_nxt.rst = 1'b1;
        end
      end
      default:
      begin
        s_nxt.st = SCB_BR_RESET;
        s_nxt.rst = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_r <= '{st: SCB_BR_RESET, cnt: '0, rst: 1'b1};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign chip_reset = s_r.rst;
endmodule

// ### dv/scb_top_sva.sv
// Purpose: port checks of scb_top
// Assumes: one clock, nrst synchronous
// Notes: bound to every scb_top
`timescale 1ns/1ps
`include "scb_cfg.svh"
module scb_top_sva
  import scb_pkg::*;
#(
  parameter int HOLD_CYCLES = `SCB_HOLD_XTAL_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic synth_tick,
  input wire logic below_low,
  input wire logic chip_reset,
  input wire logic [1:0] low_trip_level_select,
  input wire logic synth_power_down,
  input wire logic [3:0] synth_m_code,
  input wire logic [1:0] synth_n_code,
  input wire logic sys_on_synth
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_low_resets: assert property (below_low |-> ##2 chip_reset)
    else $error("no chip reset while supply low");
  chk_reset_regs: assert property (chip_reset [*2] |-> low_trip_level_select == 2'h0 && synth_power_down
    && synth_m_code == 4'h1 && synth_n_code == 2'h0)
    else $error("registers not at reset during chip reset");
  chk_reset_xtal: assert property (chip_reset [*2] |-> !sys_on_synth)
    else $error("synth source during chip reset");
  chk_synth_stable: assert property ($rose(sys_on_synth) |-> !synth_power_down)
    else $error("switched to powered-down synth");
  chk_pwdn_drop: assert property (synth_power_down |-> ##[0:4] !sys_on_synth)
    else $error("synth source kept while powered down");
  chk_switch_edge: assert property ($rose(sys_on_synth) |-> $past(synth_tick) || $past(synth_tick, 2))
    else $error("source switch not on a synth edge");
  chk_trip_write: assert property (wr && addr == `SCB_ADDR_BROWNOUT && !chip_reset
    |=> {low_trip_level_select, 6'h00} == ($past(wdata) & 8'hC0))
    else $error("trip level not written");
  chk_ratio_write: assert property (wr && addr == `SCB_ADDR_SYNTH_RATIO && !chip_reset
    |=> {synth_m_code, synth_n_code, 2'h0} == ($past(wdata) & 8'hFC))
    else $error("ratio codes not written");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule
bind scb_top scb_top_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_scb_top_sva (.*);

// ### dv/testbench.sv
// Purpose: self-checking bench of scb_top
// Assumes: hold count cut to 16 crystal ticks
// Notes: read data checked through a queue
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench
  import scb_pkg::*;
;
  localparam int HOLD = 16;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, rd_p = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, v, ev;
  logic xtal_tick = 0, synth_tick = 0, synth_locked = 0, below_low = 0, above_upper = 0;
  logic chip_reset, synth_power_down, sys_on_synth, sys_clk_tick;
  logic [1:0] low_trip_level_select, synth_n_code, synth_test_vset;
  logic [3:0] synth_m_code, synth_filter_trim;
  logic [7:0] expq[$];
  logic [15:0] ra[5] = '{16'hFF0A, 16'hFF10, 16'hFF11, 16'hFF12, 16'hFF0B};
  logic [7:0] rv[5] = '{8'h00, 8'hC1, 8'h02, 8'h10, 8'h00};
  logic [7:0] rm[5] = '{8'hC0, 8'h67, 8'h0F, 8'hFF, 8'h00};
  int failures = 0, n_compared = 0, seed = 32'h2C5A, cyc = 0, n, nx;
  scb_top #(.HOLD_CYCLES(HOLD)) i_scb_top (.*);
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    xtal_tick <= (cyc % 4) == 0;
    synth_tick <= cyc[0];
  end
  always @(posedge clk)
  begin
    if (rd_p)
    begin
      ev = expq.pop_front();
      `CHK("rdata", ev, rdata)
    end
    rd_p <= rd;
  end
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // d carries the expected value on a read
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r)
      expq.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle(input int k);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  // counts crystal ticks while waiting
  task automatic wait_sig(ref logic s, input logic lvl);
    int k;
    k = 0;
    nx = 0;
    while (s !== lvl)
    begin
      @(posedge clk);
      nx += xtal_tick;
      k++;
      if (k > 400)
      begin
        failures++;
        give_verdict();
      end
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    idle(20);
    `CHK("hold", 1'b1, chip_reset)
    above_upper <= 1'b1;
    wait_sig(chip_reset, 1'b0);
    `CHK("ticks", 1'b1, nx >= HOLD && nx <= HOLD + 2)
    for (int i = 0; i < 5; i++)
      bus(1'b0, 1'b1, ra[i], rv[i]);
    for (int i = 0; i < 5; i++)
    begin
      v = 8'($random(seed));
      bus(1'b1, 1'b0, ra[i], v);
      bus(1'b0, 1'b1, ra[i], (v & rm[i]) | ((i == 1) ? 8'h80 : 8'h00));
    end
    bus(1'b1, 0, 16'hFF12, 8'h30);
    bus(1'b1, 0, 16'hFF10, 8'h00);
    bus(1'b1, 0, 16'hFF13, 8'h01);
    idle(30);
    `CHK("early", 1'b0, sys_on_synth)
    synth_locked <= 1'b1;
    wait_sig(sys_on_synth, 1'b1);
    bus(1'b0, 1'b1, 16'hFF10, 8'h00);
    for (int d = 0; d < 4; d++)
    begin
      bus(1'b1, 1'b0, 16'hFF12, {6'h0C, d[1:0]});
      idle(40);
      n = 0;
      repeat (128) @(posedge clk) n += sys_clk_tick;
      `CHK("div", 1'b1, n >= (64 >> d) - 1 && n <= (64 >> d) + 1)
    end
    bus(1'b1, 1'b0, 16'hFF10, 8'h01);
    idle(6);
    `CHK("pwdn", 1'b0, sys_on_synth)
    bus(1'b1, 1'b0, 16'hFF0A, 8'hC0);
    below_low <= 1'b1;
    idle(3);
    `CHK("brown", 1'b1, chip_reset)
    `CHK("trip", 2'h0, low_trip_level_select)
    `CHK("trim", 4'h2, synth_filter_trim)
    `CHK("vset", 2'h2, synth_test_vset)
    below_low <= 1'b0;
    wait_sig(chip_reset, 1'b0);
    bus(1'b0, 1'b1, 16'hFF10, 8'hC1);
    idle(2);
    give_verdict();
  end
endmodule
